// >>> core/pci_nic_power_state_manager.sv
// Power state manager of a PCI network controller with an AHB-Lite register slave.
// Assumes ref_clk at 50 MHz, rst asynchronous active high as power-on reset,
// and asynchronous pins (PCI reset, power-good, hard reset) synchronised here.
`timescale 1ns/1ns
`default_nettype none
`include "pnpsm_cfg.svh"
module pci_nic_power_state_manager
(
  input  wire logic                         ref_clk,
  input  wire logic                         rst,
  input  wire logic                         hsel,
  input  wire logic [31:0]                  haddr,
  input  wire logic [1:0]                   htrans,
  input  wire logic                         hwrite,
  input  wire logic [2:0]                   hsize,
  input  wire logic [31:0]                  hwdata,
  input  wire logic                         hready,
  output logic      [31:0]                  hrdata,
  output logic                              hreadyout,
  output logic                              hresp,
  input  wire logic                         pciRstN,
  input  wire logic                         pciClk,
  input  wire logic                         powerGoodInput,
  input  wire logic                         hardResetPinN,
  input  wire logic                         auxPowerPresent,
  input  wire logic                         wakeEvent,
  output logic                              wakeRequestOut,
  output logic                              pciIntOut,
  output logic                              sysClkEnable,
  output logic                              macClkEnable,
  output logic                              clkRunReq,
  output pnpsm_pkg::pnpsm_mode_t            powerMode
);
  import pnpsm_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers; stage one is read only by stage two
  logic [4:0] syncA_r;
  logic [4:0] syncB_r;
  logic       pciRstPrev_r;
  logic       pgPrev_r;
  logic       hrstPrev_r;
  logic       pciClkPrev_r;
  wire        pciRstAct = ~syncB_r[0];
  wire        powerGood = syncB_r[1];
  wire        hardRstAct = ~syncB_r[2];
  wire        auxPresent = syncB_r[4];
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
    begin
      syncA_r <= `PNPSM_SYNC_IDLE;
      syncB_r <= `PNPSM_SYNC_IDLE;
    end
    else
    begin
      syncA_r <= {auxPowerPresent, pciClk, hardResetPinN, powerGoodInput, pciRstN};
      syncB_r <= syncA_r;
    end

  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
    begin
      pciRstPrev_r <= 1'b0;
      pgPrev_r     <= 1'b1;
      hrstPrev_r   <= 1'b0;
      pciClkPrev_r <= 1'b0;
    end
    else
    begin
      pciRstPrev_r <= pciRstAct;
      pgPrev_r     <= powerGood;
      hrstPrev_r   <= hardRstAct;
      pciClkPrev_r <= syncB_r[3];
    end

  wire pciRstRise = pciRstAct & ~pciRstPrev_r;
  wire pciRstFall = ~pciRstAct & pciRstPrev_r;
  wire pgLoss     = ~powerGood & pgPrev_r;
  wire pgReturn   = powerGood & ~pgPrev_r;
  wire hrstRise   = hardRstAct & ~hrstPrev_r;

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: one-cycle address capture, zero wait states
  logic [7:0] addr_r;
  logic       wrPend_r;
  logic       rdPend_r;
  wire        acc = hsel & hready & htrans[1];
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
    begin
      addr_r   <= 8'h00;
      wrPend_r <= 1'b0;
      rdPend_r <= 1'b0;
    end
    else
    begin
      wrPend_r <= acc & hwrite;
      rdPend_r <= acc & ~hwrite;
      if (acc)
        addr_r <= haddr[7:0];
    end
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  logic [31:0] genCtl_r;
  logic [31:0] intMask_r;
  logic [1:0]  pmState_r;
  logic        evtSt_r;
  logic        evtEn_r;
  logic        loopback_r;
  pnpsm_mode_t mode_r;
  pnpsm_boot_t boot_r;
  logic [15:0] recallCnt_r;
  logic        evtIntSt_r;

  // Unmapped addresses read zero and ignore writes
  wire wrGen  = wrPend_r & (addr_r == `PNPSM_OFS_GENCTL);
  wire wrMask = wrPend_r & (addr_r == `PNPSM_OFS_INTMASK);
  wire wrPm   = wrPend_r & (addr_r == `PNPSM_OFS_PWRMGMT);
  wire wrMisc = wrPend_r & (addr_r == `PNPSM_OFS_MISC);
  // Config space access needs the PCI clock; aux sleep has none
  wire cfgOk  = mode_r != PNPSM_AUXSLEEP;

  ////////////////////////////////////////////////////////////////////////////
  // Boot sequencer: hard reset recalls config memory then powers down
  wire recallDone = (boot_r == PNPSM_RECALL) && (recallCnt_r == `PNPSM_RECALL_CYC);
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
    begin
      boot_r      <= PNPSM_RECALL;
      recallCnt_r <= 16'h0000;
    end
    else if (hrstRise)
    begin
      boot_r      <= PNPSM_RECALL;
      recallCnt_r <= 16'h0000;
    end
    else
    begin
      unique case (boot_r)
        PNPSM_RECALL:
        begin
          recallCnt_r <= recallCnt_r + 16'h0001;
          if (recallDone)
            boot_r <= PNPSM_RUN;
        end
        PNPSM_RUN:
          recallCnt_r <= 16'h0000;
      endcase
    end

  ////////////////////////////////////////////////////////////////////////////
  // General control; auto-mode bit cleared only by power-on reset or a general control write
  wire pmEnterLow = wrPm & cfgOk & (hwdata[1:0] != `PNPSM_PSTATE_D0);
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
      genCtl_r <= 32'h0000_0000;
    else
    begin
      if (wrGen)
      begin
        genCtl_r <= hwdata & ~(32'h1 << `PNPSM_BIT_SRESET);
        // Soft reset leaves the part powered up unless a config memory recall completes in the same cycle
        if (hwdata[`PNPSM_BIT_SRESET])
          genCtl_r[`PNPSM_BIT_PDOWN] <= 1'b0;
      end
      if (recallDone)
        genCtl_r[`PNPSM_BIT_PDOWN] <= 1'b1;
      if (pmEnterLow)
        genCtl_r[`PNPSM_BIT_PDOWN] <= 1'b1;
    end

  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
    begin
      intMask_r  <= 32'h0000_0000;
      loopback_r <= 1'b0;
    end
    else
    begin
      if (wrMask & ~genCtl_r[`PNPSM_BIT_PDOWN])
        intMask_r <= hwdata;
      if (wrMisc)
        loopback_r <= hwdata[`PNPSM_BIT_LOOPB];
    end

  ////////////////////////////////////////////////////////////////////////////
  // Power state and reset effect
  wire ignRst   = genCtl_r[`PNPSM_BIT_IGNRST] | genCtl_r[`PNPSM_BIT_RSTE1];
  wire rstToD0  = ~ignRst & ((~genCtl_r[`PNPSM_BIT_RSTE0] & pciRstRise)
                           | (genCtl_r[`PNPSM_BIT_RSTE0] & pciRstFall));
  wire autoMode = genCtl_r[`PNPSM_BIT_AUTOPL];
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
    begin
      pmState_r <= `PNPSM_PSTATE_D0;
      mode_r    <= PNPSM_D0;
    end
    else if (~auxPresent & ~powerGood)
    begin
      pmState_r <= `PNPSM_PSTATE_D0;
      mode_r    <= PNPSM_UNPOWERED;
    end
    else if (autoMode & pgLoss)
    begin
      pmState_r <= `PNPSM_PSTATE_D3;
      mode_r    <= PNPSM_AUXSLEEP;
    end
    else if ((autoMode & pgReturn & (mode_r == PNPSM_AUXSLEEP)) | rstToD0)
    begin
      pmState_r <= `PNPSM_PSTATE_D0;
      mode_r    <= PNPSM_D0;
    end
    else if (wrPm & cfgOk)
    begin
      pmState_r <= hwdata[1:0];
      mode_r    <= (hwdata[1:0] == `PNPSM_PSTATE_D0) ? PNPSM_D0 : PNPSM_D3HOT;
    end
    else if (mode_r == PNPSM_UNPOWERED)
      mode_r <= PNPSM_D0;

  // Event status and enable; hardware set beats software clear, PCI reset ignored
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
    begin
      evtSt_r <= 1'b0;
      evtEn_r <= 1'b0;
    end
    else if (mode_r == PNPSM_UNPOWERED)
    begin
      evtSt_r <= 1'b0;
      evtEn_r <= 1'b0;
    end
    else
    begin
      if (wrPm & cfgOk)
        evtEn_r <= hwdata[`PNPSM_BIT_EVTEN];
      if (wakeEvent & (mode_r != PNPSM_D0))
        evtSt_r <= 1'b1;
      else if (wrPm & cfgOk & hwdata[`PNPSM_BIT_EVTST])
        evtSt_r <= 1'b0;
    end

  // Event interrupt status follows event status only; write-one does nothing
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
      evtIntSt_r <= 1'b0;
    else
      evtIntSt_r <= evtSt_r;

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  wire lowPower = mode_r != PNPSM_D0;
  wire pdown    = genCtl_r[`PNPSM_BIT_PDOWN];
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
    begin
      wakeRequestOut <= 1'b0;
      pciIntOut      <= 1'b0;
      sysClkEnable   <= 1'b1;
      macClkEnable   <= 1'b1;
      clkRunReq      <= 1'b0;
    end
    else
    begin
      wakeRequestOut <= evtSt_r & evtEn_r;
      pciIntOut      <= evtIntSt_r & lowPower & genCtl_r[`PNPSM_BIT_EVTINT]
                        & intMask_r[`PNPSM_BIT_EVTMSK];
      sysClkEnable   <= ~pdown | genCtl_r[`PNPSM_BIT_CLKON];
      macClkEnable   <= ~(pdown & loopback_r);
      clkRunReq      <= pdown;
    end
  assign powerMode = mode_r;

  // Read mux; config, general control and misc answer while powered down
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
      hrdata <= 32'h0000_0000;
    else if (acc & ~hwrite)
    begin
      unique case (haddr[7:0])
        `PNPSM_OFS_GENCTL:
          hrdata <= genCtl_r;
        `PNPSM_OFS_PWRMGMT:
          hrdata <= cfgOk ? {16'h0000, evtSt_r, 6'h00, evtEn_r, 6'h00, pmState_r} : 32'h0000_0000;
        `PNPSM_OFS_INTMASK:
          hrdata <= pdown ? 32'h0000_0000 : intMask_r;
        `PNPSM_OFS_INTSTAT:
          hrdata <= pdown ? 32'h0000_0000 : {17'h00000, evtIntSt_r, 14'h0000};
        `PNPSM_OFS_MISC:
          hrdata <= {29'h0, syncB_r[3] ^ pciClkPrev_r, loopback_r, boot_r == PNPSM_RUN};
        default:
          hrdata <= 32'h0000_0000;
      endcase
    end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  property p_rst_d0;
    @(posedge ref_clk) disable iff (rst)
    (rstToD0 && !(~auxPresent & ~powerGood) && !(autoMode & pgLoss)) |=> mode_r == PNPSM_D0;
  endproperty
  a_rst_d0: assert property (p_rst_d0) else $error("reset did not force D0");

  property p_ign;
    @(posedge ref_clk) disable iff (rst)
    (genCtl_r[`PNPSM_BIT_IGNRST] && pciRstRise && !pgLoss && !wrPm && mode_r == PNPSM_D3HOT
     && auxPresent) |=> mode_r == PNPSM_D3HOT;
  endproperty
  a_ign: assert property (p_ign) else $error("reset not ignored");

  property p_bit21;
    @(posedge ref_clk) disable iff (rst)
    (genCtl_r[`PNPSM_BIT_RSTE1] && (pciRstRise || pciRstFall) && mode_r == PNPSM_D3HOT && powerGood
     && auxPresent && !wrPm) |=> mode_r == PNPSM_D3HOT;
  endproperty
  a_bit21: assert property (p_bit21) else $error("bit 21 not honoured");

  property p_wake;
    @(posedge ref_clk) disable iff (rst)
    ##1 wakeRequestOut == $past(evtSt_r & evtEn_r);
  endproperty
  a_wake: assert property (p_wake) else $error("wake request mismatch");

  property p_int;
    @(posedge ref_clk) disable iff (rst)
    pciIntOut |-> $past(genCtl_r[`PNPSM_BIT_EVTINT] & intMask_r[`PNPSM_BIT_EVTMSK] & lowPower);
  endproperty
  a_int: assert property (p_int) else $error("interrupt without enables");

  property p_loss;
    @(posedge ref_clk) disable iff (rst)
    (autoMode && pgLoss && auxPresent) |=> mode_r == PNPSM_AUXSLEEP;
  endproperty
  a_loss: assert property (p_loss) else $error("no aux sleep on loss");

  property p_pd;
    @(posedge ref_clk) disable iff (rst)
    pmEnterLow |=> pdown ##1 (!sysClkEnable || genCtl_r[`PNPSM_BIT_CLKON]);
  endproperty
  a_pd: assert property (p_pd) else $error("power-down not set");

  property p_recall;
    @(posedge ref_clk) disable iff (rst)
    recallDone |=> pdown;
  endproperty
  a_recall: assert property (p_recall) else $error("no power-down after recall");

  property p_return;
    @(posedge ref_clk) disable iff (rst)
    (autoMode && pgReturn && mode_r == PNPSM_AUXSLEEP && auxPresent) |=> mode_r == PNPSM_D0;
  endproperty
  a_return: assert property (p_return) else $error("no D0 on power return");

  property p_unpow;
    @(posedge ref_clk) disable iff (rst)
    (!auxPresent && !powerGood) |=> mode_r == PNPSM_UNPOWERED;
  endproperty
  a_unpow: assert property (p_unpow) else $error("not unpowered without supplies");

  property p_unpow_clr;
    @(posedge ref_clk) disable iff (rst)
    mode_r == PNPSM_UNPOWERED |=> !evtSt_r && !evtEn_r;
  endproperty
  a_unpow_clr: assert property (p_unpow_clr) else $error("event bits kept without power");

  property p_set_wins;
    @(posedge ref_clk) disable iff (rst)
    (wakeEvent && mode_r != PNPSM_D0 && mode_r != PNPSM_UNPOWERED) |=> evtSt_r;
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event status not set");

  // A write in aux sleep would need the absent PCI clock
  property p_aux_cfg;
    @(posedge ref_clk) disable iff (rst)
    (mode_r == PNPSM_AUXSLEEP && wrPm && auxPresent && !powerGood && !rstToD0) |=> mode_r == PNPSM_AUXSLEEP;
  endproperty
  a_aux_cfg: assert property (p_aux_cfg) else $error("config write in aux sleep");

  property p_softrst;
    @(posedge ref_clk) disable iff (rst)
    (wrGen && hwdata[`PNPSM_BIT_SRESET] && !recallDone) |=> !pdown && !genCtl_r[`PNPSM_BIT_SRESET];
  endproperty
  a_softrst: assert property (p_softrst) else $error("soft reset left power-down set");

  c_loss:  cover property (@(posedge ref_clk) disable iff (rst) mode_r == PNPSM_AUXSLEEP ##[1:50] mode_r == PNPSM_D0);
  c_unpow: cover property (@(posedge ref_clk) disable iff (rst) mode_r == PNPSM_UNPOWERED ##1 mode_r == PNPSM_D0);
  c_wake:  cover property (@(posedge ref_clk) disable iff (rst) $rose(wakeRequestOut));
  c_int:   cover property (@(posedge ref_clk) disable iff (rst) $rose(pciIntOut));
endmodule
`default_nettype wire

// >>> core/pnpsm_cfg.svh
// Constants of the power state manager: register offsets, bit positions, reset values.
// Assumes inclusion by core/pci_nic_power_state_manager.sv and the bench top, not by core/pnpsm_pkg.sv.
//
// Contract
// - Aux-powered sleep behaves like D3 hot; configuration access is impossible there.
// - Unpowered state: no scanning, no bus transactions, internal state lost.
// - Control bit 17 set makes the device ignore PCI reset transitions.
// - Control bit 16 set keeps the system clock running in low power states.
// - Reset-effect bits 00: PCI reset assertion forces D0 immediately.
// - Reset-effect bits 01: assertion no effect; deassertion sets D0.
// - Reset-effect bit 21 set: PCI reset never changes the power state.
// - Event drives interrupt in low power only if control bit 19 and mask bit 14.
// - Writing status bit 14 does not clear event interrupt; clearing event status does.
// - Power-on reset clears event status and enable, sets power state 00.
// - Auto power-loss enable clears at power-up, survives power loss and PCI reset.
// - Power-good high means present; with auto mode, loss enters aux-powered sleep.
// - With auto mode, power-good returning moves aux-powered sleep to D0.
// - Power-down bit gates system clock; in loopback also gates transmit and receive clocks.
// - While powered down, configuration and general control remain accessible.
// - Hard reset recalls serial configuration memory, then enters power-down.
// - Writing zero powers up; cleared before soft reset, stays cleared after.
// - Power-down leaves PCI clock running; clock-run protocol lets host stop it.
// - Wake request asserted while event status and enable both set.
// - Event status and enable survive PCI reset; only power-up clears them.
// - Entering D3 hot, D1 or D2 sets power-down bit 3.
`ifndef PNPSM_CFG_SVH
`define PNPSM_CFG_SVH
`define PNPSM_OFS_INTSTAT 8'h04
`define PNPSM_OFS_INTMASK 8'h08
`define PNPSM_OFS_GENCTL  8'h0c
`define PNPSM_OFS_PWRMGMT 8'he0
`define PNPSM_OFS_MISC    8'h40
`define PNPSM_BIT_PDOWN   3
`define PNPSM_BIT_SRESET  0
`define PNPSM_BIT_CLKON   16
`define PNPSM_BIT_IGNRST  17
`define PNPSM_BIT_WAKEPAT 18
`define PNPSM_BIT_EVTINT  19
`define PNPSM_BIT_RSTE0   20
`define PNPSM_BIT_RSTE1   21
`define PNPSM_BIT_AUTOPL  22
`define PNPSM_BIT_EVTMSK  14
`define PNPSM_BIT_EVTST   15
`define PNPSM_BIT_EVTEN   8
`define PNPSM_BIT_LOOPB   1
`define PNPSM_RECALL_CYC  16'h0040
`define PNPSM_PSTATE_D0   2'h0
`define PNPSM_PSTATE_D3   2'h3
// Idle levels of aux, PCI clock, hard reset, power-good, PCI reset: no false edge after reset
`define PNPSM_SYNC_IDLE   5'h17
`endif

// >>> core/pnpsm_pkg.sv
// Types of the power state manager.
// Assumes nothing beyond the constants header.
package pnpsm_pkg;
  typedef enum logic [1:0] {PNPSM_D0, PNPSM_D3HOT, PNPSM_AUXSLEEP, PNPSM_UNPOWERED} pnpsm_mode_t;
  typedef enum {PNPSM_RECALL, PNPSM_RUN} pnpsm_boot_t;
endpackage

// >>> tb/pnpsm_host_model.sv
// Far side model: the PCI host clock source.
// Assumes power-good gates the host's PCI power; clock-run request from the block.
`timescale 1ns/1ns
`default_nettype none
module pnpsm_host_model
(
  input  wire logic powerGood,
  input  wire logic clkRunReq,
  output logic      pciClk
);
  initial pciClk = 1'b0;
  // No clock without PCI power; host stops it while clock-run asks
  always
  begin
    #80;
    if (powerGood && !clkRunReq)
      pciClk = ~pciClk;
    else
      pciClk = 1'b0;
  end
endmodule
`default_nettype wire

// >>> tb/pci_nic_power_state_manager_tb_top.sv
// Self-checking bench of the power state manager over AHB-Lite.
// Assumes the host model as far side and a slave that answers in any number of cycles.
`timescale 1ns/1ns
`default_nettype none
`include "pnpsm_cfg.svh"
module pci_nic_power_state_manager_tb_top;
  import pnpsm_pkg::*;
  logic        ref_clk, rst, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        pciRstN, pciClk, powerGoodInput, hardResetPinN, auxPowerPresent, wakeEvent;
  logic        wakeRequestOut, pciIntOut, sysClkEnable, macClkEnable, clkRunReq;
  pnpsm_mode_t powerMode;
  int          error_cnt, check_count;
  assign hready = hreadyout;
  pci_nic_power_state_manager DUT (.ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pciRstN(pciRstN), .pciClk(pciClk),
    .powerGoodInput(powerGoodInput), .hardResetPinN(hardResetPinN),
    .auxPowerPresent(auxPowerPresent), .wakeEvent(wakeEvent), .wakeRequestOut(wakeRequestOut),
    .pciIntOut(pciIntOut), .sysClkEnable(sysClkEnable), .macClkEnable(macClkEnable),
    .clkRunReq(clkRunReq), .powerMode(powerMode));
  pnpsm_host_model host (.powerGood(powerGoodInput), .clkRunReq(clkRunReq), .pciClk(pciClk));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic fail(input string s);
    error_cnt++;
    $display("CHECK FAILED at %0t: %s", $time, s);
  endtask
  task automatic tally_and_finish();
    if (error_cnt == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk);
    #2;
  endtask
  // Address phase held until hready, then data phase held until hready
  task automatic ahb(input logic wr, input logic [7:0] ofs, input logic [31:0] wd);
    @(posedge ref_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, ofs};
    hwrite <= wr;
    do @(posedge ref_clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge ref_clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] ofs, input logic [31:0] d);
    ahb(1'b1, ofs, d);
  endtask
  task automatic rdchk(input logic [7:0] ofs, input logic [31:0] e, input logic [31:0] m);
    ahb(1'b0, ofs, 32'h0);
    check_count++;
    if ((rd & m) !== e)
      fail($sformatf("read %h gave %h expected %h", ofs, rd & m, e));
  endtask
  task automatic chkBit(input logic g, input logic e, input string s);
    check_count++;
    if (g !== e)
      fail(s);
  endtask
  // Bounded wait covers the synchroniser and edge detect delay
  task automatic chkMode(input pnpsm_mode_t e);
    int n;
    n = 0;
    while (powerMode !== e && n < 40)
    begin
      settle(1);
      n++;
    end
    check_count++;
    if (powerMode !== e)
      fail("power mode");
  endtask
  task automatic pulse();
    @(posedge ref_clk);
    wakeEvent <= 1'b1;
    @(posedge ref_clk);
    wakeEvent <= 1'b0;
    settle(3);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  initial
  begin
    #200000;
    fail("watchdog");
    tally_and_finish();
  end
  initial
  begin
    {rst, hsel, haddr, htrans, hwrite, hwdata, wakeEvent} = {1'b1, 69'h0};
    hsize = 3'h2;
    {pciRstN, powerGoodInput, hardResetPinN, auxPowerPresent} = 4'hf;
    error_cnt = 0;
    check_count = 0;
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    settle(1);
    chkMode(PNPSM_D0);
    rdchk(`PNPSM_OFS_PWRMGMT, 32'h0, 32'h8103);
    chkBit(hresp, 1'b0, "bus response");
    settle(80);
    rdchk(`PNPSM_OFS_GENCTL, 32'h8, 32'h8);
    chkBit(sysClkEnable, 1'b0, "system clock gate");
    chkBit(clkRunReq, 1'b1, "clock run request");
    rdchk(8'h80, 32'h0, 32'hffffffff);
    // No traffic runs in this bench, so the controller is idle here
    wr(`PNPSM_OFS_MISC, 32'h2);
    wr(`PNPSM_OFS_GENCTL, 32'h10008);
    settle(3);
    chkBit(sysClkEnable, 1'b1, "clock keep");
    chkBit(macClkEnable, 1'b0, "loopback clocks");
    wr(`PNPSM_OFS_GENCTL, 32'h0);
    wr(`PNPSM_OFS_MISC, 32'h0);
    settle(3);
    chkBit(sysClkEnable, 1'b1, "power up");
    chkBit(macClkEnable, 1'b1, "mac clocks");
    // Soft reset with power-down clear: both bits read back zero
    wr(`PNPSM_OFS_GENCTL, 32'h1);
    rdchk(`PNPSM_OFS_GENCTL, 32'h0, 32'h9);
    wr(`PNPSM_OFS_INTMASK, 32'h4000);
    wr(`PNPSM_OFS_GENCTL, 32'hc0000);
    wr(`PNPSM_OFS_PWRMGMT, 32'h103);
    chkMode(PNPSM_D3HOT);
    rdchk(`PNPSM_OFS_GENCTL, 32'h8, 32'h8);
    chkBit(wakeRequestOut, 1'b0, "wake idle");
    pulse();
    chkBit(wakeRequestOut, 1'b1, "wake set");
    chkBit(pciIntOut, 1'b1, "event interrupt");
    wr(`PNPSM_OFS_INTSTAT, 32'h4000);
    settle(3);
    chkBit(pciIntOut, 1'b1, "status write kept interrupt");
    wr(`PNPSM_OFS_PWRMGMT, 32'h3);
    settle(3);
    chkBit(wakeRequestOut, 1'b0, "enable cleared");
    wr(`PNPSM_OFS_PWRMGMT, 32'h103);
    settle(3);
    chkBit(wakeRequestOut, 1'b1, "enable again");
    wr(`PNPSM_OFS_PWRMGMT, 32'h8103);
    settle(3);
    chkBit(wakeRequestOut, 1'b0, "status cleared");
    chkBit(pciIntOut, 1'b0, "interrupt cleared");
    wr(`PNPSM_OFS_GENCTL, 32'h8);
    pulse();
    chkBit(pciIntOut, 1'b0, "interrupt not enabled");
    wr(`PNPSM_OFS_PWRMGMT, 32'h8103);
    // Reset-effect codes 00..11, then ignore bit with code 00
    for (int k = 0; k < 5; k++)
    begin
      wr(`PNPSM_OFS_PWRMGMT, 32'h100);
      chkMode(PNPSM_D0);
      wr(`PNPSM_OFS_GENCTL, (k == 4) ? 32'h420000 : (32'h400000 | (k << 20)));
      wr(`PNPSM_OFS_PWRMGMT, 32'h103);
      chkMode(PNPSM_D3HOT);
      @(posedge ref_clk);
      pciRstN <= 1'b0;
      settle(8);
      chkMode((k == 0) ? PNPSM_D0 : PNPSM_D3HOT);
      @(posedge ref_clk);
      pciRstN <= 1'b1;
      settle(8);
      chkMode((k < 2) ? PNPSM_D0 : PNPSM_D3HOT);
      rdchk(`PNPSM_OFS_PWRMGMT, 32'h100, 32'h100);
      rdchk(`PNPSM_OFS_GENCTL, 32'h400000, 32'h400000);
    end
    // Everything configured before power is lost
    wr(`PNPSM_OFS_PWRMGMT, 32'h100);
    chkMode(PNPSM_D0);
    @(posedge ref_clk);
    powerGoodInput <= 1'b0;
    chkMode(PNPSM_AUXSLEEP);
    wr(`PNPSM_OFS_PWRMGMT, 32'h0);
    settle(3);
    chkMode(PNPSM_AUXSLEEP);
    @(posedge ref_clk);
    powerGoodInput <= 1'b1;
    chkMode(PNPSM_D0);
    @(posedge ref_clk);
    auxPowerPresent <= 1'b0;
    powerGoodInput <= 1'b0;
    chkMode(PNPSM_UNPOWERED);
    @(posedge ref_clk);
    auxPowerPresent <= 1'b1;
    powerGoodInput <= 1'b1;
    settle(8);
    rdchk(`PNPSM_OFS_PWRMGMT, 32'h0, 32'h8100);
    wr(`PNPSM_OFS_GENCTL, 32'h0);
    @(posedge ref_clk);
    hardResetPinN <= 1'b0;
    settle(4);
    @(posedge ref_clk);
    hardResetPinN <= 1'b1;
    settle(90);
    rdchk(`PNPSM_OFS_GENCTL, 32'h8, 32'h8);
    tally_and_finish();
  end
endmodule
`default_nettype wire
